//--- core_exec_sleep_ret_rot_sub_test.sv
// Self-checking bench for the execution block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module core_exec_sleep_ret_rot_sub_test;
    import exec_pkg::*;
    logic mclk_i = 0, reset_i = 1, issue_i = 0, dest_i = 0, wake_i = 0;
    op_t op_i = OP_NONE;
    logic [6:0] reg_addr_i = 0, reg_waddr_o;
    logic [7:0] reg_data_i = 0, literal_i = 0, acc_o, reg_wdata_o, a = 0, e, m;
    logic [12:0] stack_top_i = 0, pc_o;
    logic carry_o, nibble_overflow_bit_o, zero_o, powerdown_status_n_o, timeout_status_n_o;
    logic watchdog_clear_o, stack_pop_o, pc_load_o, reg_we_o, osc_run_o, busy_o;
    logic c = 0, n = 0, z = 0;
    int miscompares = 0, num_checks = 0, cyc = 0;
    logic [31:0] rng = 82817;
    exec_core u_dut (.*);
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // Leaves issue high so calls run back to back
    task automatic run(op_t o, logic d, logic [7:0] f, logic [7:0] k);
        issue_i = 1;
        op_i = o;
        dest_i = d;
        reg_data_i = f;
        literal_i = k;
        reg_addr_i = rng[22:16];
        @(posedge mclk_i);
        #1;
        if (o == OP_ROTATE) begin
            e = {c, f[7:1]};
            c = f[0];
        end else begin
            m = (o == OP_SUB_LIT) ? k : f;
            e = m - a;
            c = m >= a;
            n = m[3:0] >= a[3:0];
            z = e == 8'h00;
        end
        if (d && o != OP_SUB_LIT) `CHK({reg_we_o, reg_waddr_o, reg_wdata_o}, {1'b1, reg_addr_i, e})
        else begin
            a = e;
            `CHK(reg_we_o, 1'b0)
        end
        `CHK({acc_o, carry_o, nibble_overflow_bit_o, zero_o}, {a, c, n, z})
    endtask : run
    initial forever #5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) if (++cyc > 3000) begin
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        #1 reset_i = 0;
        run(OP_SUB_REG, 1, 8'h00, 0);
        run(OP_SUB_LIT, 0, 0, 8'h10);
        run(OP_SUB_LIT, 0, 0, 8'h10);
        run(OP_SUB_LIT, 0, 0, 8'h0f);
        run(OP_SUB_LIT, 0, 0, 8'h00);
        run(OP_ROTATE, 0, 8'h01, 0);
        run(OP_ROTATE, 1, 8'h80, 0);
        repeat (300) begin
            rng = xs(rng);
            run(op_t'(3 + rng[25:24] % 3), rng[26], rng[7:0], rng[15:8]);
        end
        $display("Arithmetic test done");
        op_i = OP_RETURN;
        stack_top_i = 13'h1a5c;
        @(posedge mclk_i);
        #1 op_i = OP_SLEEP;
        `CHK({stack_pop_o, pc_load_o, pc_o, busy_o}, {2'b11, 13'h1a5c, 1'b1})
        `CHK({acc_o, carry_o, nibble_overflow_bit_o, zero_o}, {a, c, n, z})
        @(posedge mclk_i);
        #1 `CHK({stack_pop_o, busy_o, watchdog_clear_o}, 3'b000)
        @(posedge mclk_i);
        #1 op_i = OP_SUB_LIT;
        literal_i = 8'h55;
        `CHK({watchdog_clear_o, powerdown_status_n_o, timeout_status_n_o, osc_run_o}, 4'ha)
        repeat (6) @(posedge mclk_i);
        #1 `CHK({osc_run_o, busy_o, watchdog_clear_o}, 3'b010)
        `CHK({acc_o, reg_we_o}, {a, 1'b0})
        wake_i = 1;
        @(posedge mclk_i);
        #1 wake_i = 0;
        issue_i = 0;
        `CHK({osc_run_o, busy_o, acc_o}, {2'b10, a})
        $display("Return and sleep test done");
        reset_i = 1;
        @(posedge mclk_i);
        #1 `CHK({powerdown_status_n_o, timeout_status_n_o}, {PD_N_RST, TO_N_RST})
        `CHK({osc_run_o, busy_o, stack_pop_o, pc_load_o}, {OSC_RUN_RST, BUSY_RST, 2'b00})
        `CHK({acc_o, carry_o, nibble_overflow_bit_o, zero_o}, {ACC_RST, {3{FLAG_RST}}})
        `CHK({pc_o, watchdog_clear_o, reg_we_o}, {PC_RST, 2'b00})
        reset_i = 0;
        a = ACC_RST;
        c = FLAG_RST;
        n = FLAG_RST;
        z = FLAG_RST;
        run(OP_SUB_LIT, 0, 0, 8'h3c);
        $display("Reset test done");
        give_verdict();
    end
endmodule : core_exec_sleep_ret_rot_sub_test

//--- exec_core.sv
// Execute stage for power-down, return, rotate right and both subtracts
`timescale 1ns/1ps
module exec_core (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic issue_i,
    input wire exec_pkg::op_t op_i,
    input wire logic dest_i,
    input wire logic [exec_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_data_i,
    input wire logic [7:0] literal_i,
    input wire logic [exec_pkg::PC_W-1:0] stack_top_i,
    input wire logic wake_i,
    output logic [7:0] acc_o,
    output logic carry_o,
    output logic nibble_overflow_bit_o,
    output logic zero_o,
    output logic powerdown_status_n_o,
    output logic timeout_status_n_o,
    output logic watchdog_clear_o,
    output logic stack_pop_o,
    output logic [exec_pkg::PC_W-1:0] pc_o,
    output logic pc_load_o,
    output logic reg_we_o,
    output logic [exec_pkg::ADDR_W-1:0] reg_waddr_o,
    output logic [7:0] reg_wdata_o,
    output logic osc_run_o,
    output logic busy_o
);
    import exec_pkg::*;

    state_t state_q;
    logic running;
    logic take;
    logic take_sleep;
    logic take_return;
    logic take_rotate;
    logic take_sub_lit;
    logic take_sub_reg;
    logic take_sub;
    logic take_alu;
    logic alu_to_reg;
    logic halt_stay;
    logic [7:0] sub_a;
    logic [7:0] diff;
    logic sub_c;
    logic sub_dc;
    logic sub_z;
    logic [7:0] rot_res;
    logic [7:0] result;

    // New instructions are only taken while running; a refused issue is dropped
    assign running = (state_q == ST_RUN);
    assign take = issue_i && running;
    assign take_sleep = take && (op_i == OP_SLEEP);
    assign take_return = take && (op_i == OP_RETURN);
    assign take_rotate = take && (op_i == OP_ROTATE);
    assign take_sub_lit = take && (op_i == OP_SUB_LIT);
    assign take_sub_reg = take && (op_i == OP_SUB_REG);
    assign take_sub = take_sub_lit || take_sub_reg;
    // Only rotate and register subtract honour the destination bit
    assign take_alu = take_rotate || take_sub_reg;
    assign alu_to_reg = take_alu && (dest_i == DEST_REG);
    // The edge that sees wake already leaves the halt
    assign halt_stay = (state_q == ST_HALT) && !wake_i;

    assign sub_a = (op_i == OP_SUB_LIT) ? literal_i : reg_data_i;
    assign rot_res = {carry_o, reg_data_i[7:1]};
    assign result = (op_i == OP_ROTATE) ? rot_res : diff;

    exec_sub u_sub (
        .minuend_i(sub_a),
        .subtrahend_i(acc_o),
        .diff_o(diff),
        .carry_o(sub_c),
        .nibble_o(sub_dc),
        .zero_o(sub_z)
    );

    // Sequencer: return holds a second cycle, power-down halts until wake
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= ST_RUN;
        end else begin
            unique case (state_q)
                ST_RUN: begin
                    if (take_return) begin
                        state_q <= ST_RET2;
                    end else if (take_sleep) begin
                        state_q <= ST_HALT;
                    end
                end
                ST_RET2: begin
                    state_q <= ST_RUN;
                end
                ST_HALT: begin
                    if (!halt_stay) begin
                        state_q <= ST_RUN;
                    end
                end
                // The unused code falls back to run rather than lock up
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Busy is high exactly while the current state is not run
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            busy_o <= BUSY_RST;
        end else begin
            busy_o <= take_return || take_sleep || halt_stay;
        end
    end

    // Oscillator stops for the whole halt
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            osc_run_o <= OSC_RUN_RST;
        end else begin
            osc_run_o <= !(take_sleep || halt_stay);
        end
    end

    // One pulse; the watchdog clears its counter and prescaler together on it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            watchdog_clear_o <= 1'b0;
        end else begin
            watchdog_clear_o <= take_sleep;
        end
    end

    // Status bits move only on power-down here; wake logic outside owns the rest
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            powerdown_status_n_o <= PD_N_RST;
        end else if (take_sleep) begin
            powerdown_status_n_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            timeout_status_n_o <= TO_N_RST;
        end else if (take_sleep) begin
            timeout_status_n_o <= 1'b1;
        end
    end

    // Pop and load share one edge, so the popped top reaches the PC at once
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            stack_pop_o <= 1'b0;
            pc_load_o <= 1'b0;
        end else begin
            stack_pop_o <= take_return;
            pc_load_o <= take_return;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pc_o <= PC_RST;
        end else if (take_return) begin
            pc_o <= stack_top_i;
        end
    end

    // Literal subtract ignores the destination bit and always lands here
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            acc_o <= ACC_RST;
        end else if (take_sub_lit) begin
            acc_o <= diff;
        end else if (take_alu && (dest_i == DEST_ACC)) begin
            acc_o <= result;
        end
    end

    // Address and data hold after a write; only the one-cycle strobe marks it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            reg_we_o <= 1'b0;
            reg_waddr_o <= '0;
            reg_wdata_o <= 8'h00;
        end else begin
            reg_we_o <= alu_to_reg;
            if (alu_to_reg) begin
                reg_waddr_o <= reg_addr_i;
                reg_wdata_o <= result;
            end
        end
    end

    // Carry: rotate shifts the old low bit out, subtracts give not-borrow
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            carry_o <= FLAG_RST;
        end else if (take_rotate) begin
            carry_o <= reg_data_i[0];
        end else if (take_sub) begin
            carry_o <= sub_c;
        end
    end

    // Nibble flag: only the subtracts touch it, return and rotate leave it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            nibble_overflow_bit_o <= FLAG_RST;
        end else if (take_sub) begin
            nibble_overflow_bit_o <= sub_dc;
        end
    end

    // Zero: subtracts only
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            zero_o <= FLAG_RST;
        end else if (take_sub) begin
            zero_o <= sub_z;
        end
    end
endmodule : exec_core

//--- exec_core_chk.sv
// Concurrent checks on the execution block ports
`timescale 1ns/1ps
module exec_core_chk (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic issue_i,
    input wire exec_pkg::op_t op_i,
    input wire logic dest_i,
    input wire logic [exec_pkg::PC_W-1:0] stack_top_i,
    input wire logic wake_i,
    input wire logic stack_pop_o,
    input wire logic [exec_pkg::PC_W-1:0] pc_o,
    input wire logic busy_o,
    input wire logic watchdog_clear_o,
    input wire logic powerdown_status_n_o,
    input wire logic timeout_status_n_o,
    input wire logic osc_run_o,
    input wire logic reg_we_o,
    input wire logic [7:0] acc_o
);
    import exec_pkg::*;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // Issues during busy are dropped, so only these count
    wire logic go = issue_i && !busy_o;
    ret_pop_a: assert property (go && op_i == OP_RETURN |=> stack_pop_o && pc_o == $past(stack_top_i)) else $error("return load wrong");
    ret_busy_a: assert property (stack_pop_o |-> busy_o ##1 !busy_o && !stack_pop_o) else $error("return length wrong");
    sleep_flags_a: assert property (go && op_i == OP_SLEEP |=> watchdog_clear_o && !powerdown_status_n_o && timeout_status_n_o) else $error("sleep side effects wrong");
    sleep_halt_a: assert property (watchdog_clear_o |-> !osc_run_o && busy_o) else $error("no halt after sleep");
    halt_hold_a: assert property (!osc_run_o && !wake_i |=> !osc_run_o) else $error("halt left without wake");
    dest_we_a: assert property (go && op_i inside {OP_ROTATE, OP_SUB_REG} |=> reg_we_o == $past(dest_i)) else $error("destination write wrong");
    dest_keep_a: assert property (go && dest_i && op_i inside {OP_ROTATE, OP_SUB_REG} |=> $stable(acc_o)) else $error("accumulator changed");
    lit_acc_a: assert property (go && op_i == OP_SUB_LIT |=> !reg_we_o) else $error("literal result left accumulator");
    cover property (go && op_i == OP_SLEEP);
    cover property (stack_pop_o);
    cover property (reg_we_o ##1 reg_we_o);
endmodule : exec_core_chk
bind exec_core exec_core_chk u_chk (.*);

//--- exec_pkg.sv
// Constants and types for the five-instruction execution block
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int PC_W = 13;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic PD_N_RST = 1'b1;
    localparam logic TO_N_RST = 1'b1;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic FLAG_RST = 1'b0;
    localparam logic OSC_RUN_RST = 1'b1;
    localparam logic BUSY_RST = 1'b0;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SLEEP = 3'h1,
        OP_RETURN = 3'h2,
        OP_ROTATE = 3'h3,
        OP_SUB_LIT = 3'h4,
        OP_SUB_REG = 3'h5
    } op_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_RET2 = 2'b01,
        ST_HALT = 2'b10
    } state_t;
endpackage : exec_pkg

//--- exec_sub.sv
// Two's complement subtractor with borrow-style flags
`timescale 1ns/1ps
module exec_sub (
    input wire logic [7:0] minuend_i,
    input wire logic [7:0] subtrahend_i,
    output logic [7:0] diff_o,
    output logic carry_o,
    output logic nibble_o,
    output logic zero_o
);
    logic [8:0] full;
    logic [4:0] low;
    // Minuend plus inverted subtrahend plus one; carry out means no borrow
    assign full = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + 9'h001;
    assign low = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + 5'h01;
    assign diff_o = full[7:0];
    assign carry_o = full[8];
    assign nibble_o = low[4];
    assign zero_o = (full[7:0] == 8'h00);
endmodule : exec_sub
